// *** common/lpmc_map.svh ***
`ifndef LPMC_MAP_SVH
`define LPMC_MAP_SVH

// register offsets (8-bit special-function address space)
`define LPMC_OFS_POWER_CONTROL 8'h87
`define LPMC_OFS_IDLE_PENDING 8'h8E
`define LPMC_OFS_STOP_PENDING 8'h8F
`define LPMC_OFS_CLOCK_CONTROL 8'hC8

// power_control field positions
`define LPMC_BIT_IDLE_REQ 0
`define LPMC_BIT_STOP_REQ 1
`define LPMC_BIT_EMU_FLAG 2
`define LPMC_BIT_SW_RESET 5

// clock_control field position: 0 fast oscillator, 1 slow oscillator
`define LPMC_BIT_CLK_SEL 0

// reset value and pending-register mask
`define LPMC_RST_BYTE 8'h00
`define LPMC_PEND_MASK 8'h7F

// soft reset pulse length and stop gate counter load, in clock cycles
`define LPMC_SOFTWARE_RESET_REQUEST_CYCLES 4'h4
`define LPMC_STOP_GATE_CYCLES 2'h1

`endif

// *** common/lpmc_pkg.sv ***
`default_nettype none

package lpmc_pkg;

    typedef enum logic [4:0] {
        LPMC_RUN = 5'h01,
        LPMC_IDLE = 5'h02,
        LPMC_STOP_GATE = 5'h04,
        LPMC_STOP = 5'h08,
        LPMC_RESTORE = 5'h10
    } lpmc_mode_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lpmc_bus_req_t;

    // idle pending sources, one bit per idle_pending_status bit
    typedef struct packed {
        logic grp6_pending;
        logic grp5_pending;
        logic grp4_pending;
        logic timer1_overflow_pending;
        logic ext_int1_pending;
        logic timer0_overflow_pending;
        logic ext_int0_pending;
    } lpmc_idle_src_t;

    // stop wake sources, one bit per stop_pending_status bit
    typedef struct packed {
        logic grp6_wake_flag;
        logic grp5_wake_flag;
        logic [2:0] ext_int_high_wake_flag;
        logic [1:0] ext_int_low_wake_flag;
    } lpmc_stop_src_t;

    // clock gate controls to the clock tree
    typedef struct packed {
        logic cpu_halt;
        logic master_clk_gate;
        logic clk_gen_off;
        logic slow_clk_sel;
    } lpmc_clk_ctl_t;

endpackage

`default_nettype wire

// *** logic/lpmc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for a vector of asynchronous levels
module lpmc_sync #(
    parameter int W = 7
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= d_i;
            stage2 <= stage1;
        end
    end

    assign q_o = stage2;

endmodule

`default_nettype wire

// *** logic/lpmc_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "lpmc_map.svh"

// Contract
// [R1] idle entered when idle pending all zero
// [R2] idle request ignored while idle pending set
// [R3] idle halts cpu, master clock keeps running
// [R4] any reset or interrupt leaves idle
// [R5] wake restores clock before taking interrupt
// [R6] idle request bit self-clears on exit
// [R7] software puts two nops after idle
// [R8] stop halts master clock and generators
// [R9] stop entered only when stop pending zero
// [R10] listed wake sources end stop mode
// [R11] stop request bit self-clears on exit
// [R12] clock gated at final edge before stopped
// [R13] software puts three nops after stop
// [R14] software prefers internal clock before stop
// [R15] soft reset bit pulses, then self-clears
// [R16] bit2 emulation flag, bits 1,0 requests
// [R17] idle pending register reports interrupt groups
// [R18] stop pending register reports wake sources
// [R19] slow oscillator select runs logic slowly
// [R20] software slows master clock before idle
// [R21] clock select: 0 fast, 1 slow
module lpmc_ctrl (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // pending and wake sources from the interrupt logic
    input wire lpmc_pkg::lpmc_idle_src_t idle_src_i,
    input wire lpmc_pkg::lpmc_stop_src_t stop_src_i,
    input wire logic clk_monitor_int_i,
    input wire logic any_int_i,
    input wire logic emulation_i,
    // clock tree and reset outputs
    output lpmc_pkg::lpmc_clk_ctl_t clk_ctl_o,
    output logic soft_reset_o,
    output logic wake_int_o,
    output logic [4:0] mode_o
);

    typedef struct packed {
        lpmc_pkg::lpmc_mode_t mode;
        logic idle_req;
        logic stop_req;
        logic clk_sel;
        logic [3:0] software_reset_request_cnt;
        logic [1:0] gate_cnt;
        logic [7:0] rdata;
        lpmc_pkg::lpmc_clk_ctl_t clk_ctl;
        logic soft_reset;
        logic wake_int;
    } lpmc_state_t;

    lpmc_state_t st;
    lpmc_state_t next_st;

    logic [6:0] idle_pend_sync;
    logic [6:0] stop_pend_sync;
    logic [1:0] misc_sync;
    logic [7:0] idle_pending_bits;
    logic [7:0] stop_pending_bits;
    logic idle_wake;
    logic stop_wake;
    // emulation strap, two flops after the pin
    logic misc_emu;
    logic emu_s1;

    // all interrupt sources arrive from outside this clock and are synced
    lpmc_sync #(.W(7)) u_idle_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .d_i(idle_src_i),
        .q_o(idle_pend_sync)
    );

    lpmc_sync #(.W(7)) u_stop_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .d_i(stop_src_i),
        .q_o(stop_pend_sync)
    );

    lpmc_sync #(.W(2)) u_misc_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .d_i({clk_monitor_int_i, any_int_i}),
        .q_o(misc_sync)
    );

    // true when the address matches the given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign idle_pending_bits = {1'b0, idle_pend_sync} & `LPMC_PEND_MASK; // R17
    assign stop_pending_bits = {1'b0, stop_pend_sync} & `LPMC_PEND_MASK; // R18

    // any interrupt wakes idle; reset is handled by rst_i itself
    assign idle_wake = misc_sync[0] | (|idle_pending_bits); // R4
    // external, low-voltage, wake timer, watchdog, touch, clock monitor
    assign stop_wake = (|stop_pending_bits) | misc_sync[1]; // R10

    always_comb begin
        next_st = st;
        next_st.wake_int = 1'b0;

        // soft reset pulse, bit self-clears when the pulse is done
        if (st.software_reset_request_cnt != 4'h0) begin
            next_st.software_reset_request_cnt = st.software_reset_request_cnt - 4'h1; // R15
        end
        next_st.soft_reset = (next_st.software_reset_request_cnt != 4'h0); // R15

        case (st.mode)
            lpmc_pkg::LPMC_RUN: begin
                if (st.stop_req) begin
                    if (stop_pending_bits == `LPMC_RST_BYTE) begin
                        next_st.mode = lpmc_pkg::LPMC_STOP_GATE; // R9
                        next_st.gate_cnt = `LPMC_STOP_GATE_CYCLES;
                    end else begin
                        next_st.stop_req = 1'b0; // R9
                    end
                end else if (st.idle_req) begin
                    if (idle_pending_bits == `LPMC_RST_BYTE) begin
                        next_st.mode = lpmc_pkg::LPMC_IDLE; // R1
                    end else begin
                        // refused: stay running, drop the request
                        next_st.idle_req = 1'b0; // R2
                    end
                end
            end
            lpmc_pkg::LPMC_IDLE: begin
                if (idle_wake) begin
                    next_st.idle_req = 1'b0; // R6
                    next_st.mode = lpmc_pkg::LPMC_RESTORE; // R5
                end
            end
            lpmc_pkg::LPMC_STOP_GATE: begin
                // last edge closes the system clock, then fully stopped
                if (st.gate_cnt != 2'h0) begin
                    next_st.gate_cnt = st.gate_cnt - 2'h1; // R12
                end else begin
                    next_st.mode = lpmc_pkg::LPMC_STOP; // R12
                end
            end
            lpmc_pkg::LPMC_STOP: begin
                if (stop_wake) begin
                    next_st.stop_req = 1'b0; // R11
                    next_st.mode = lpmc_pkg::LPMC_RESTORE; // R5
                end
            end
            lpmc_pkg::LPMC_RESTORE: begin
                // clock is back this cycle; the interrupt is passed on next
                next_st.wake_int = 1'b1; // R5
                next_st.mode = lpmc_pkg::LPMC_RUN;
            end
            default: begin
                next_st.mode = lpmc_pkg::LPMC_RUN;
            end
        endcase

        // register writes; idle and stop requests are only accepted while running, soft reset in any mode
        if (wr_i && hit(addr_i, `LPMC_OFS_POWER_CONTROL)) begin
            if (wdata_i[`LPMC_BIT_SW_RESET]) begin
                next_st.software_reset_request_cnt = `LPMC_SOFTWARE_RESET_REQUEST_CYCLES; // R15
                next_st.soft_reset = 1'b1;
            end
            if (st.mode == lpmc_pkg::LPMC_RUN) begin
                next_st.stop_req = wdata_i[`LPMC_BIT_STOP_REQ]; // R16
                next_st.idle_req = wdata_i[`LPMC_BIT_IDLE_REQ]; // R16
            end
        end
        if (wr_i && hit(addr_i, `LPMC_OFS_CLOCK_CONTROL)) begin
            next_st.clk_sel = wdata_i[`LPMC_BIT_CLK_SEL]; // R21
        end

        // read data stands in the cycle after the strobe only
        next_st.rdata = `LPMC_RST_BYTE;
        if (rd_i) begin
            if (hit(addr_i, `LPMC_OFS_POWER_CONTROL)) begin
                // request bits are write-only and read as zero
                next_st.rdata[`LPMC_BIT_EMU_FLAG] = misc_emu; // R16
            end else if (hit(addr_i, `LPMC_OFS_IDLE_PENDING)) begin
                next_st.rdata = idle_pending_bits; // R17
            end else if (hit(addr_i, `LPMC_OFS_STOP_PENDING)) begin
                next_st.rdata = stop_pending_bits; // R18
            end else if (hit(addr_i, `LPMC_OFS_CLOCK_CONTROL)) begin
                next_st.rdata[`LPMC_BIT_CLK_SEL] = st.clk_sel; // R21
            end
        end

        // clock tree controls follow the next mode; slow select follows the next clk_sel
        next_st.clk_ctl.cpu_halt =
            (next_st.mode != lpmc_pkg::LPMC_RUN); // R3
        next_st.clk_ctl.master_clk_gate =
            (next_st.mode == lpmc_pkg::LPMC_STOP); // R8
        next_st.clk_ctl.clk_gen_off =
            (next_st.mode == lpmc_pkg::LPMC_STOP); // R8
        next_st.clk_ctl.slow_clk_sel = next_st.clk_sel; // R19
    end

    // emulation strap captured by a clocked process after reset
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            emu_s1 <= 1'b0;
            misc_emu <= 1'b0;
        end else begin
            emu_s1 <= emulation_i;
            misc_emu <= emu_s1; // R16
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '{mode: lpmc_pkg::LPMC_RUN, default: '0}; // R4
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign clk_ctl_o = st.clk_ctl;
    assign soft_reset_o = st.soft_reset;
    assign wake_int_o = st.wake_int;
    assign mode_o = st.mode;

endmodule

`default_nettype wire

// *** verif/lpmc_ctrl_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module lpmc_ctrl_asserts (
    // clock, reset, bus
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // sources and outputs
    input wire lpmc_pkg::lpmc_idle_src_t idle_src_i,
    input wire lpmc_pkg::lpmc_stop_src_t stop_src_i,
    input wire logic clk_monitor_int_i,
    input wire logic any_int_i,
    input wire logic emulation_i,
    input wire lpmc_pkg::lpmc_clk_ctl_t clk_ctl_o,
    input wire logic soft_reset_o,
    input wire logic wake_int_o,
    input wire logic [4:0] mode_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    sequence s_idle_wr;
        wr_i && addr_i == 8'h87 && wdata_i == 8'h01 && mode_o == 5'h01
            && idle_src_i == 7'h00 && stop_src_i == 7'h00;
    endsequence
    sequence s_stop_gate;
        (mode_o == 5'h04) [*2];
    endsequence
    property p_idle_enter;
        s_idle_wr |-> ##2 mode_o == 5'h02;
    endproperty
    property p_idle_halt;
        mode_o == 5'h02 |-> clk_ctl_o.cpu_halt && !clk_ctl_o.master_clk_gate;
    endproperty
    property p_idle_wake;
        mode_o == 5'h02 && any_int_i |-> ##[1:5] mode_o == 5'h10;
    endproperty
    property p_restore;
        mode_o == 5'h10 |=> mode_o == 5'h01 && wake_int_o;
    endproperty
    property p_stop_gate;
        mode_o == 5'h08 |-> clk_ctl_o.master_clk_gate && clk_ctl_o.clk_gen_off;
    endproperty
    property p_stop_seq;
        $rose(mode_o == 5'h04) |-> s_stop_gate ##1 mode_o == 5'h08;
    endproperty
    property p_stop_wake;
        mode_o == 5'h08 && clk_monitor_int_i |-> ##[1:5] mode_o == 5'h10;
    endproperty
    property p_software_reset_request;
        $rose(soft_reset_o) |-> soft_reset_o [*4] ##1 !soft_reset_o;
    endproperty
    property p_rdata;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    a_idle_enter: assert property (p_idle_enter)
        else $error("idle not entered");
    a_idle_halt: assert property (p_idle_halt)
        else $error("idle clock state wrong");
    a_idle_wake: assert property (p_idle_wake)
        else $error("idle not left");
    a_restore: assert property (p_restore)
        else $error("restore not followed by wake");
    a_stop_gate: assert property (p_stop_gate)
        else $error("stop clocks running");
    a_stop_seq: assert property (p_stop_seq)
        else $error("stop gate sequence wrong");
    a_stop_wake: assert property (p_stop_wake)
        else $error("stop not left");
    a_software_reset_request: assert property (p_software_reset_request)
        else $error("soft reset length wrong");
    a_rdata: assert property (p_rdata)
        else $error("read data outside slot");
endmodule
bind lpmc_ctrl lpmc_ctrl_asserts chk_u (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .idle_src_i(idle_src_i), .stop_src_i(stop_src_i),
    .clk_monitor_int_i(clk_monitor_int_i), .any_int_i(any_int_i),
    .emulation_i(emulation_i), .clk_ctl_o(clk_ctl_o),
    .soft_reset_o(soft_reset_o), .wake_int_o(wake_int_o), .mode_o(mode_o));
`default_nettype wire

// *** verif/lpmc_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// cpu side bus master; keeps quiet slots after a mode request
module lpmc_cpu_model (
    // clock and read data
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    // request
    output lpmc_pkg::lpmc_bus_req_t req_o
);
    initial req_o = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        req_o.wr <= 1'b0;
        if (a == 8'h87) begin
            repeat (d[1] ? 3 : d[0] ? 2 : 0) @(posedge clock_i);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        req_o.rd <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// *** verif/tb_low_power_mode_controller.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_low_power_mode_controller;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    lpmc_pkg::lpmc_idle_src_t idle_src = '0;
    lpmc_pkg::lpmc_stop_src_t stop_src = '0;
    logic clk_mon = 1'b0;
    logic any_int = 1'b0;
    logic emu = 1'b0;
    lpmc_pkg::lpmc_bus_req_t req;
    lpmc_pkg::lpmc_clk_ctl_t clk_ctl;
    logic [7:0] rdata;
    logic [7:0] d;
    logic soft_reset;
    logic wake_int;
    logic [4:0] mode;
    int errors = 0;
    int checked = 0;
    always #2 clock_i = ~clock_i;
    lpmc_cpu_model cpu_u (.clock_i(clock_i), .rdata_i(rdata), .req_o(req));
    lpmc_ctrl dut_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(req.addr),
        .wdata_i(req.wdata), .wr_i(req.wr), .rd_i(req.rd), .rdata_o(rdata),
        .idle_src_i(idle_src), .stop_src_i(stop_src),
        .clk_monitor_int_i(clk_mon), .any_int_i(any_int),
        .emulation_i(emu), .clk_ctl_o(clk_ctl), .soft_reset_o(soft_reset),
        .wake_int_o(wake_int), .mode_o(mode));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        cpu_u.rd(a, d);
        cmp(d, e);
    endtask
    task automatic settle();
        repeat (4) @(posedge clock_i);
        #1;
    endtask
    task automatic wait_wake();
        int n;
        n = 0;
        while (wake_int !== 1'b1 && n < 10) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        cmp({7'h00, wake_int}, 8'h01);
    endtask
    task automatic t_regs();
        rdc(8'h87, 8'h00);
        rdc(8'h8E, 8'h00);
        rdc(8'h8F, 8'h00);
        rdc(8'hC8, 8'h00);
        rdc(8'h55, 8'h00);
        cpu_u.wr(8'h8F, 8'hFF);
        rdc(8'h8F, 8'h00);
        @(posedge clock_i);
        emu <= 1'b1;
        settle();
        rdc(8'h87, 8'h04);
        @(posedge clock_i);
        emu <= 1'b0;
        $display("regs done");
    endtask
    task automatic t_idle();
        @(posedge clock_i);
        idle_src <= 7'h49;
        settle();
        rdc(8'h8E, 8'h49);
        cpu_u.wr(8'h87, 8'h01);
        settle();
        cmp({3'h0, mode}, 8'h01);
        @(posedge clock_i);
        idle_src <= 7'h00;
        cpu_u.wr(8'hC8, 8'h01);
        settle();
        cpu_u.wr(8'h87, 8'h01);
        settle();
        cmp({3'h0, mode}, 8'h02);
        cmp({4'h0, clk_ctl}, 8'h09);
        @(posedge clock_i);
        any_int <= 1'b1;
        @(posedge clock_i);
        any_int <= 1'b0;
        wait_wake();
        cmp({4'h0, clk_ctl}, 8'h01);
        rdc(8'h87, 8'h00);
        settle();
        cmp({3'h0, mode}, 8'h01);
        $display("idle done");
    endtask
    task automatic t_stop();
        cpu_u.wr(8'hC8, 8'h00);
        @(posedge clock_i);
        stop_src <= 7'h21;
        settle();
        rdc(8'h8F, 8'h21);
        cpu_u.wr(8'h87, 8'h02);
        settle();
        cmp({3'h0, mode}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i);
            stop_src <= 7'h00;
            clk_mon <= 1'b0;
            settle();
            cpu_u.wr(8'h87, 8'h02);
            settle();
            cmp({3'h0, mode}, 8'h08);
            cmp({4'h0, clk_ctl}, 8'h0E);
            @(posedge clock_i);
            if (i < 7) stop_src <= 7'(1 << i);
            else clk_mon <= 1'b1;
            @(posedge clock_i);
            stop_src <= 7'h00;
            clk_mon <= 1'b0;
            wait_wake();
            rdc(8'h87, 8'h00);
            settle();
            cmp({3'h0, mode}, 8'h01);
        end
        @(posedge clock_i);
        clk_mon <= 1'b0;
        stop_src <= 7'h00;
        $display("stop done");
    endtask
    task automatic t_misc();
        int n;
        n = 0;
        cpu_u.wr(8'h87, 8'h20);
        repeat (10) begin
            #1;
            n += soft_reset;
            @(posedge clock_i);
        end
        cmp(n[7:0], 8'h04);
        rdc(8'h87, 8'h00);
        cpu_u.wr(8'hC8, 8'h01);
        rdc(8'hC8, 8'h01);
        cmp({7'h0, clk_ctl.slow_clk_sel}, 8'h01);
        cpu_u.wr(8'hC8, 8'h00);
        rdc(8'hC8, 8'h00);
        $display("misc done");
    endtask
    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        settle();
        t_regs();
        t_idle();
        t_stop();
        t_misc();
        test_done();
    end
    initial begin
        #40000;
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
